// *** rcm_pkg.sv ***
// Purpose: constants and carrier types for the reset cause and low-voltage control block
// Assumes: 50 MHz system clock, classic Wishbone register access
// Notes:   byte addresses taken as printed offsets from the peripheral base
package rcm_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [23:0] RESET_CONTROL_OFS = 24'h11_0000;
  localparam logic [23:0] RESET_CAUSE_OFS   = 24'h11_0001;
  localparam logic [7:0]  RESET_CONTROL_RST = 8'h05;
  localparam logic [7:0]  RESET_CAUSE_RST   = 8'h00;
  localparam logic [7:0]  CONTROL_WR_MASK   = 8'hCD;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SW_RESET_REQUEST_BIT   = 7;
  localparam int FORCE_RESET_OUT_BIT    = 6;
  localparam int LOW_VOLTAGE_FLAG_BIT   = 4;
  localparam int LV_IRQ_ENABLE_BIT      = 3;
  localparam int LV_RESET_ENABLE_BIT    = 2;
  localparam int LOW_VOLTAGE_ENABLE_BIT = 0;
  localparam int LOW_VOLTAGE_CAUSE_BIT  = 6;
  localparam int SW_CAUSE_BIT           = 5;
  localparam int POR_CAUSE_BIT          = 3;
  localparam int PIN_RESET_CAUSE_BIT    = 2;
  localparam int REF_FAIL_CAUSE_BIT     = 1;
  localparam int PLL_UNLOCK_CAUSE_BIT   = 0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ           = 50_000_000;
  localparam int PIN_QUAL_EDGES   = 4;
  localparam int RELEASE_CYCLES   = 512;
  localparam logic [3:0] PIN_QUAL_LAST  = 4'(PIN_QUAL_EDGES - 1);
  localparam logic [9:0] RELEASE_LAST   = 10'(RELEASE_CYCLES - 1);

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic        por;
    logic        low_voltage;
    logic        ref_fail;
    logic        pll_unlock;
  } async_src_t;

  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_HOLD_PIN,
    SEQ_WAIT_LOCK,
    SEQ_COUNT
  } seq_state_t;

endpackage

// *** pin_qualify.sv ***
// Purpose: two-stage synchroniser plus assertion-length qualifier for the reset input pin
// Assumes: reset_in_pin_n_i is active low and asynchronous to clk_i
// Notes:   stop mode bypasses the synchroniser; the raw level is then used
module pin_qualify
  import rcm_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic stop_mode_i,
  input  wire logic reset_in_pin_n_i,
  output logic      asserted_o,
  output logic      qualified_o
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic [3:0] cnt;
    logic       qual;
  } pq_state_t;

  pq_state_t st_ff;
  pq_state_t nxt_st;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = ~reset_in_pin_n_i;
    nxt_st.sync2 = st_ff.sync1;
    if (!st_ff.sync2) begin
      nxt_st.cnt  = 4'h0;
      nxt_st.qual = 1'b0;
    end else if (st_ff.cnt == PIN_QUAL_LAST) begin
      nxt_st.qual = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // stop mode: act on the raw pin
  assign asserted_o  = stop_mode_i ? ~reset_in_pin_n_i : st_ff.sync2;
  assign qualified_o = stop_mode_i ? ~reset_in_pin_n_i : st_ff.qual;

endmodule

// *** reset_cause_and_lvd_control.sv ***
// Purpose: reset control and reset cause registers with low-voltage detector control
// Assumes: classic Wishbone slave, 8-bit data in the low lane; one system clock
// Notes:   asynchronous sources arrive as levels already in the clk_i domain
//
// How it works
// - reset input is synchronised except in stop mode, where it acts directly
// - 8-bit read/write control register, resets to 0x05; internal resets keep bit 6, only rst_i or a write of 0 clears it
// - 8-bit cause register readable always, writes ignored
// - writing 1 to bit 7 requests software reset; that reset clears it
// - bit 6 drives reset output pin directly; 1 asserts it
// - bit 4 flags low voltage while detector enabled; write 1 clears
// - interrupt when flag, detector enable, irq enable set and reset enable clear
// - low-voltage interrupt shares vector with edge input zero; software arbitrates
// - system reset leaves the flag alone; it reads 0 after reset
// - bit 3 enables the interrupt, no effect when detector disabled
// - bit 2 enables low-voltage reset with detector on; reset beats interrupt
// - bit 0 turns the low-voltage detector on or off
// - entering reset captures 1 for pending sources, 0 for others
// - several causes may set together; each reset replaces the whole pattern
// - cause bit 6 low voltage, bit 5 software
// - cause bit 3 power-on, bit 2 external pin
// - cause bit 1 loss of clock, bit 0 loss of lock
// - reset output pin is active low, low while chip held in reset
// - after input negates and lock, count 512 cycles before release
// - power-on sets power-on and low-voltage causes only
//
// The implementer's own choice: the Wishbone interface to the registers.
module reset_cause_and_lvd_control
  import rcm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [23:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        reset_in_pin_n_i,
  input  wire logic        stop_mode_i,
  input  wire logic        por_i,
  input  wire logic        low_voltage_i,
  input  wire logic        ref_fail_i,
  input  wire logic        pll_unlock_i,
  input  wire logic        pll_locked_i,
  output logic             reset_out_pin_n_o,
  output logic             chip_reset_o,
  output logic             low_voltage_irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    seq_state_t  seq;
    logic [9:0]  cnt;
    logic [7:0]  ctrl;
    logic [7:0]  cause;
    logic        lv_flag;
    logic        por_seq;
    logic        ack;
    logic [31:0] dat;
    logic        pin_n;
    logic        chip_rst;
    logic        irq;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  logic pin_asserted;
  logic pin_qualified;

  pin_qualify u_pin (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .stop_mode_i      (stop_mode_i),
    .reset_in_pin_n_i (reset_in_pin_n_i),
    .asserted_o       (pin_asserted),
    .qualified_o      (pin_qualified)
  );

  function automatic logic hit(input logic [23:0] adr, input logic [23:0] ofs);
    hit = (adr == ofs);
  endfunction

  logic wr_ctrl;
  logic lv_enabled;
  logic lv_reset;
  logic async_any;
  logic [7:0] wr_val;
  logic [7:0] cap;

  always_comb begin
    wr_ctrl    = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack
                 && hit(wb_adr_i, RESET_CONTROL_OFS) && wb_sel_i[0];
    wr_val     = wb_dat_i[7:0];
    lv_enabled = st_ff.ctrl[LOW_VOLTAGE_ENABLE_BIT];
    lv_reset   = lv_enabled && st_ff.ctrl[LV_RESET_ENABLE_BIT] && low_voltage_i;
    async_any  = por_i || lv_reset || ref_fail_i || pll_unlock_i;
    cap        = 8'h00;
    cap[LOW_VOLTAGE_CAUSE_BIT] = lv_reset;
    cap[SW_CAUSE_BIT]          = st_ff.ctrl[SW_RESET_REQUEST_BIT];
    cap[PIN_RESET_CAUSE_BIT]   = pin_qualified;
    cap[REF_FAIL_CAUSE_BIT]    = ref_fail_i;
    cap[PLL_UNLOCK_CAUSE_BIT]  = pll_unlock_i;
    if (por_i || st_ff.por_seq) begin
      cap = 8'h00;
      cap[POR_CAUSE_BIT]         = 1'b1;
      cap[LOW_VOLTAGE_CAUSE_BIT] = 1'b1;
    end

    nxt_st = st_ff;

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
    nxt_st.dat = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !st_ff.ack && !wb_we_i) begin
      if (hit(wb_adr_i, RESET_CONTROL_OFS)) begin
        nxt_st.dat[7:0] = {st_ff.ctrl[7:5], st_ff.lv_flag, st_ff.ctrl[3:0]};
      end else if (hit(wb_adr_i, RESET_CAUSE_OFS)) begin
        nxt_st.dat[7:0] = st_ff.cause;
      end
    end
    if (wr_ctrl) begin
      nxt_st.ctrl = wr_val & CONTROL_WR_MASK;
      if (wr_val[LOW_VOLTAGE_FLAG_BIT]) begin
        nxt_st.lv_flag = 1'b0;
      end
    end
    // set beats the write-one clear
    if (lv_enabled && low_voltage_i) begin
      nxt_st.lv_flag = 1'b1;
    end

    // ----------------------------------------
    // reset sequence
    // ----------------------------------------
    unique case (st_ff.seq)
      SEQ_RUN: begin
        if (async_any) begin
          nxt_st.cause = cap;
          nxt_st.seq   = SEQ_WAIT_LOCK;
        end else if (pin_qualified || st_ff.ctrl[SW_RESET_REQUEST_BIT]) begin
          nxt_st.cause = cap;
          nxt_st.seq   = SEQ_HOLD_PIN;
        end
      end
      SEQ_HOLD_PIN: begin
        if (!pin_asserted) begin
          nxt_st.seq = SEQ_WAIT_LOCK;
        end
      end
      SEQ_WAIT_LOCK: begin
        nxt_st.cnt = 10'h000;
        if (pll_locked_i && !pll_unlock_i) begin
          nxt_st.seq = SEQ_COUNT;
        end
      end
      SEQ_COUNT: begin
        nxt_st.cnt = st_ff.cnt + 10'h001;
        if (st_ff.cnt == RELEASE_LAST) begin
          nxt_st.seq     = SEQ_RUN;
          nxt_st.por_seq = 1'b0;
        end
      end
    endcase
    if (st_ff.seq != SEQ_RUN) begin
      if (por_i || lv_reset) begin
        nxt_st.seq = SEQ_WAIT_LOCK;
        if (!st_ff.por_seq) begin
          nxt_st.cause = cap;
        end
      end else if (pin_qualified && st_ff.seq != SEQ_HOLD_PIN) begin
        nxt_st.seq = SEQ_HOLD_PIN;
      end else if ((ref_fail_i || pll_unlock_i) && st_ff.seq == SEQ_COUNT) begin
        nxt_st.seq = SEQ_WAIT_LOCK;
      end
      nxt_st.ctrl = RESET_CONTROL_RST | (st_ff.ctrl & 8'h40);
    end
    if (por_i) begin
      nxt_st.por_seq = 1'b1;
    end
    nxt_st.chip_rst = (nxt_st.seq != SEQ_RUN);
    nxt_st.pin_n    = !(nxt_st.chip_rst || nxt_st.ctrl[FORCE_RESET_OUT_BIT]);
    nxt_st.irq      = nxt_st.lv_flag && nxt_st.ctrl[LOW_VOLTAGE_ENABLE_BIT]
                      && nxt_st.ctrl[LV_IRQ_ENABLE_BIT]
                      && !nxt_st.ctrl[LV_RESET_ENABLE_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff.seq      <= SEQ_RUN;
      st_ff.cnt      <= 10'h000;
      st_ff.ctrl     <= RESET_CONTROL_RST;
      st_ff.cause    <= RESET_CAUSE_RST;
      st_ff.lv_flag  <= 1'b0;
      st_ff.por_seq  <= 1'b0;
      st_ff.ack      <= 1'b0;
      st_ff.dat      <= 32'h0000_0000;
      st_ff.pin_n    <= 1'b1;
      st_ff.chip_rst <= 1'b0;
      st_ff.irq      <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o          = st_ff.dat;
  assign wb_ack_o          = st_ff.ack;
  assign reset_out_pin_n_o = st_ff.pin_n;
  assign chip_reset_o      = st_ff.chip_rst;
  assign low_voltage_irq_o = st_ff.irq;

endmodule

// *** rcm_properties.sv ***
// Purpose: bus and reset-pin timing checks for the reset cause block
// Assumes: sees only top-level ports; one clock domain
// Notes:   attached by bind from the bench top
module rcm_properties (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        reset_out_pin_n_o,
  input  wire logic        chip_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_dat_byte_only: assert property (wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_pin_follows_hold: assert property (chip_reset_o |-> !reset_out_pin_n_o)
    else $error("reset pin high while chip held");
  a_hold_min_len: assert property ($rose(chip_reset_o) |-> chip_reset_o [*8])
    else $error("reset hold too short");
  a_reset_outputs_idle: assert property ($fell(rst_i) |-> reset_out_pin_n_o && !chip_reset_o)
    else $error("outputs wrong after reset");
endmodule

// *** reset_board_model.sv ***
// Purpose: board side: reset pin driver and pll lock behaviour
// Assumes: pin has a pull-up, so it idles high
// Notes:   lock drops for 20 cycles after each unlock event
module reset_board_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] hold_i,
  input  wire logic       unlock_i,
  output logic            reset_in_pin_n_o,
  output logic            pll_locked_o
);
  logic [7:0] pin_cnt_ff  = 8'h00;
  logic [7:0] lock_cnt_ff = 8'h00;
  always @(posedge clk_i) begin
    if (go_i) pin_cnt_ff <= hold_i;
    else if (pin_cnt_ff != 8'h00) pin_cnt_ff <= pin_cnt_ff - 8'h01;
    if (unlock_i) lock_cnt_ff <= 8'h14;
    else if (lock_cnt_ff != 8'h00) lock_cnt_ff <= lock_cnt_ff - 8'h01;
  end
  assign reset_in_pin_n_o = (pin_cnt_ff == 8'h00);
  assign pll_locked_o     = (lock_cnt_ff == 8'h00);
endmodule

// *** reset_cause_and_lvd_control_bench.sv ***
// Purpose: self-checking bench for the reset cause and low-voltage block
// Assumes: classic Wishbone master, one cycle ack
// Notes:   each internal reset takes about 520 cycles
module reset_cause_and_lvd_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rcm_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, stop_mode = 0, por = 0;
  logic low_v = 0, ref_fail = 0, unlock = 0, go = 0, wb_ack, rst_pin_n, locked;
  logic rst_out_n, chip_rst, lv_irq;
  logic [23:0] wb_adr = 24'h00_0000;
  logic [3:0]  wb_sel = 4'h1;
  logic [31:0] wb_wdat = 32'h0000_0000, wb_rdat, seed = 32'h0000_4F50;
  logic [7:0]  hold = 8'h00, rd, d;
  logic [7:0]  modes [3] = '{8'h09, 8'h01, 8'h08};
  logic [7:0]  irqs [3] = '{8'h01, 8'h00, 8'h00};
  logic [7:0]  flags [3] = '{8'h10, 8'h10, 8'h00};
  int          err_total = 0, samples_checked = 0;
  always #10 clk_i = ~clk_i;
  reset_cause_and_lvd_control uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .reset_in_pin_n_i(rst_pin_n),
    .stop_mode_i(stop_mode), .por_i(por), .low_voltage_i(low_v), .ref_fail_i(ref_fail),
    .pll_unlock_i(unlock), .pll_locked_i(locked), .reset_out_pin_n_o(rst_out_n),
    .chip_reset_o(chip_rst), .low_voltage_irq_o(lv_irq));
  reset_board_model board (.clk_i(clk_i), .go_i(go), .hold_i(hold),
    .unlock_i(ref_fail | unlock), .reset_in_pin_n_o(rst_pin_n), .pll_locked_o(locked));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [23:0] a, input logic [7:0] v, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= {24'h00_0000, v};
    wb_sel <= s;
    do begin @(posedge clk_i); n++; end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("MISMATCH %0t no ack from register bus", $time);
    end
    rd = wb_rdat[7:0];
    wb_cyc <= 0;
    wb_stb <= 0;
    wb_we <= 0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [23:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00, 4'h1);
    chk(rd, exp);
  endtask
  task automatic wait_rst(input logic [7:0] cause);
    int n;
    n = 0;
    while (chip_rst !== 1'b1 && n < 30) begin @(posedge clk_i); n++; end
    chk({7'h00, rst_out_n}, 8'h00);
    n = 0;
    while (chip_rst !== 1'b0 && n < 3000) begin @(posedge clk_i); n++; end
    chk(8'(n >= 512), 8'h01);
    rdchk(RESET_CAUSE_OFS, cause);
    $display("reset test done, cause %h", cause);
  endtask
  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rdchk(RESET_CONTROL_OFS, RESET_CONTROL_RST);
    rdchk(RESET_CAUSE_OFS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = xs() & 8'h5D;
      wb(1'b1, RESET_CONTROL_OFS, d, 4'h1);
      rdchk(RESET_CONTROL_OFS, d & 8'h4D);
      chk({7'h00, rst_out_n}, {7'h00, ~d[6]});
    end
    wb(1'b1, RESET_CONTROL_OFS, 8'h05, 4'h1);
    wb(1'b1, RESET_CONTROL_OFS, 8'h41, 4'h0);
    rdchk(RESET_CONTROL_OFS, 8'h05);
    wb(1'b1, RESET_CAUSE_OFS, 8'hFF, 4'h1);
    rdchk(RESET_CAUSE_OFS, 8'h00);
    wb(1'b1, 24'h11_0002, 8'hFF, 4'h1);
    rdchk(24'h11_0002, 8'h00);
    $display("register access test done");
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, RESET_CONTROL_OFS, modes[i] | 8'h10, 4'h1);
      low_v <= 1;
      repeat (4) @(posedge clk_i);
      low_v <= 0;
      repeat (2) @(posedge clk_i);
      chk({7'h00, lv_irq}, irqs[i]);
      rdchk(RESET_CONTROL_OFS, modes[i] | flags[i]);
    end
    $display("low voltage flag test done");
    wb(1'b1, RESET_CONTROL_OFS, 8'h80, 4'h1);
    wait_rst(8'h20);
    rdchk(RESET_CONTROL_OFS, 8'h05);
    hold <= 8'h02;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
    repeat (12) @(posedge clk_i);
    chk({7'h00, chip_rst}, 8'h00);
    hold <= 8'h06;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
    wait_rst(8'h04);
    wb(1'b1, RESET_CONTROL_OFS, 8'h0D, 4'h1);
    low_v <= 1;
    repeat (3) @(posedge clk_i);
    low_v <= 0;
    chk({7'h00, lv_irq}, 8'h00);
    wait_rst(8'h40);
    ref_fail <= 1;
    unlock <= 1;
    @(posedge clk_i);
    ref_fail <= 0;
    unlock <= 0;
    wait_rst(8'h03);
    stop_mode <= 1;
    hold <= 8'h02;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
    wait_rst(8'h04);
    stop_mode <= 0;
    por <= 1;
    repeat (3) @(posedge clk_i);
    por <= 0;
    repeat (10) @(posedge clk_i);
    unlock <= 1;
    @(posedge clk_i);
    unlock <= 0;
    wait_rst(8'h48);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rdchk(RESET_CONTROL_OFS, RESET_CONTROL_RST);
    end_of_test();
  end
endmodule
bind reset_cause_and_lvd_control rcm_properties props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .reset_out_pin_n_o(reset_out_pin_n_o), .chip_reset_o(chip_reset_o));
